// file: verilog/mvps_regs.svh
// Register map, reset values and timing figures of the valve motor stepper.
// Assumes a 100 MHz system clock and a 12-bit APB byte address.
`ifndef MVPS_REGS_SVH
`define MVPS_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MVPS_OFF_CTRL      12'h000
`define MVPS_OFF_STROKE    12'h004
`define MVPS_OFF_RESTART   12'h008
`define MVPS_OFF_BAND      12'h00c
`define MVPS_OFF_HYST      12'h010
`define MVPS_OFF_STATUS    12'h014

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define MVPS_CTRL_EN_BIT   0
`define MVPS_TIME_MSB      13
`define MVPS_PCT_MSB       14
`define MVPS_ST_OPEN_BIT   0
`define MVPS_ST_CLOSE_BIT  1
`define MVPS_ST_LOCK_BIT   2
`define MVPS_ST_LOCKD_BIT  3
`define MVPS_ST_DIR_LSB    4
`define MVPS_ST_DIR_MSB    5
`define MVPS_ST_CNT_LSB    8
`define MVPS_ST_CNT_MSB    25

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MVPS_RST_EN        1'h0
`define MVPS_RST_STROKE    14'h0000
`define MVPS_RST_RESTART   14'h0000
`define MVPS_RST_BAND      15'h0000
`define MVPS_RST_HYST      15'h0000

// ----------------------------------------------------------------------
// Scaling and timing
// ----------------------------------------------------------------------
// Percent values are in 0.01 %, so full scale 100.00 % is this figure
`define MVPS_PCT_FULL      32'd10000
// Operation cycle of 0.1 s, times are counted in these cycles
`define MVPS_OP_CYCLE_NS   100000000
`define MVPS_CLK_PERIOD_NS 10
`define MVPS_CNT_LAST      18'h00001
`define MVPS_CNT_ZERO      18'h00000

`endif

// file: verilog/mvps_pkg.sv
// Types shared by the valve motor stepper and its cycle tick generator.
// Assumes mvps_regs.svh for all figures; holds types only.
package mvps_pkg;

  typedef enum logic [1:0] {
    MVPS_IDLE,
    MVPS_DRIVE,
    MVPS_LOCK
  } mvps_st_e;

  typedef enum logic [1:0] {
    MVPS_DIR_NONE,
    MVPS_DIR_OPEN,
    MVPS_DIR_CLOSE
  } mvps_dir_e;

  typedef struct packed {
    mvps_st_e    st;
    mvps_dir_e   last_dir;
    logic        locked;
    logic [17:0] cnt;
    logic        drv_open;
    logic        drv_close;
    logic        enable;
    logic [13:0] stroke;
    logic [13:0] restart;
    logic [14:0] band;
    logic [14:0] hyst;
    logic [31:0] prdata;
    logic        slverr;
  } mvps_state_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } mvps_tick_s;

endpackage : mvps_pkg

// file: verilog/mvps_tick.sv
// Operation cycle tick: one-cycle pulse every CYCLES clocks.
// Assumes a free-running clock; restarts its count at reset.
`timescale 1ns/1ps
`include "mvps_regs.svh"

module mvps_tick #(
  parameter int unsigned CYCLES = 10000000
) (
  input  wire logic clk_sys,  // System clock
  input  wire logic rstn,     // Async reset, active low
  output logic      tick      // One-cycle operation pulse
);

  mvps_pkg::mvps_tick_s s_ff;
  mvps_pkg::mvps_tick_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt >= CYCLES - 1) begin
      nxt_s.cnt  = 32'h0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;

endmodule : mvps_tick

// file: verilog/mvps_top.sv
// Position-proportional valve motor stepper with APB configuration.
// Assumes signed percent inputs in 0.01 % and an APB master on clk_sys.
`timescale 1ns/1ps
`include "mvps_regs.svh"

module mvps_top #(
  parameter int unsigned OP_CYCLE_CLKS =
    `MVPS_OP_CYCLE_NS / `MVPS_CLK_PERIOD_NS
) (
  input  wire logic        clk_sys,              // System clock
  input  wire logic        rstn,                 // Async reset, active low
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB write
  input  wire logic [11:0] paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic      [31:0] prdata,               // APB read data
  output logic             pready,               // APB ready
  output logic             pslverr,              // APB error
  input  wire logic [15:0] manipulated_value_in, // Demand, 0.01 %
  input  wire logic [15:0] opening_feedback_in,  // Opening, 0.01 %
  output logic             open_drive_out,       // Motor open contact
  output logic             close_drive_out       // Motor close contact
);

  mvps_pkg::mvps_state_s s_ff;
  mvps_pkg::mvps_state_s nxt_s;

  logic                 tick;
  logic signed [16:0]   dev;
  logic        [16:0]   abs_dev;
  logic                 outside;
  mvps_pkg::mvps_dir_e  want_dir;
  logic                 rev;
  logic        [31:0]   base_prod;
  logic        [31:0]   hyst_prod;
  logic        [17:0]   base_ticks;
  logic        [17:0]   hyst_ticks;
  logic        [17:0]   pulse_ticks;
  logic                 wr_en;
  logic                 rd_setup;
  logic                 addr_ok;

  mvps_tick #(
    .CYCLES (OP_CYCLE_CLKS)
  ) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tick    (tick)
  );

  // ----------------------------------------------------------------------
  // Deviation and pulse length
  // ----------------------------------------------------------------------
  assign dev = $signed({manipulated_value_in[15], manipulated_value_in})
             - $signed({opening_feedback_in[15], opening_feedback_in});
  assign abs_dev = dev[16] ? 17'(-dev) : 17'(dev);
  assign outside = s_ff.enable && (abs_dev > {2'h0, s_ff.band});
  assign want_dir = (dev > 17'sh0) ? mvps_pkg::MVPS_DIR_OPEN
                                   : mvps_pkg::MVPS_DIR_CLOSE;
  assign rev = (s_ff.last_dir != mvps_pkg::MVPS_DIR_NONE)
            && (want_dir != s_ff.last_dir);
  // Stroke is in 0.1 s, equal to one operation cycle, so no rescale
  assign base_prod = 32'({18'h0, s_ff.stroke} * {15'h0, abs_dev});
  assign hyst_prod = 32'({18'h0, s_ff.stroke} * {17'h0, s_ff.hyst});
  assign base_ticks = 18'(base_prod / `MVPS_PCT_FULL);
  assign hyst_ticks = 18'(hyst_prod / `MVPS_PCT_FULL);
  assign pulse_ticks = rev ? 18'(base_ticks + hyst_ticks) : base_ticks;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign addr_ok  = (paddr == `MVPS_OFF_CTRL)    ||
                    (paddr == `MVPS_OFF_STROKE)  ||
                    (paddr == `MVPS_OFF_RESTART) ||
                    (paddr == `MVPS_OFF_BAND)    ||
                    (paddr == `MVPS_OFF_HYST)    ||
                    (paddr == `MVPS_OFF_STATUS);

  always_comb begin
    nxt_s = s_ff;
    // Configuration writes, status is read only
    if (wr_en) begin
      case (paddr)
        `MVPS_OFF_CTRL:    nxt_s.enable  = pwdata[`MVPS_CTRL_EN_BIT];
        `MVPS_OFF_STROKE:  nxt_s.stroke  = pwdata[`MVPS_TIME_MSB:0];
        `MVPS_OFF_RESTART: nxt_s.restart = pwdata[`MVPS_TIME_MSB:0];
        `MVPS_OFF_BAND:    nxt_s.band    = pwdata[`MVPS_PCT_MSB:0];
        `MVPS_OFF_HYST:    nxt_s.hyst    = pwdata[`MVPS_PCT_MSB:0];
        default:           nxt_s.enable  = s_ff.enable;
      endcase
    end
    // Read data captured in setup so the access phase needs no wait
    if (rd_setup) begin
      nxt_s.slverr = !addr_ok;
      nxt_s.prdata = 32'h0;
      case (paddr)
        `MVPS_OFF_CTRL:    nxt_s.prdata[`MVPS_CTRL_EN_BIT] = s_ff.enable;
        `MVPS_OFF_STROKE:  nxt_s.prdata[`MVPS_TIME_MSB:0] = s_ff.stroke;
        `MVPS_OFF_RESTART: nxt_s.prdata[`MVPS_TIME_MSB:0] = s_ff.restart;
        `MVPS_OFF_BAND:    nxt_s.prdata[`MVPS_PCT_MSB:0] = s_ff.band;
        `MVPS_OFF_HYST:    nxt_s.prdata[`MVPS_PCT_MSB:0] = s_ff.hyst;
        `MVPS_OFF_STATUS: begin
          nxt_s.prdata[`MVPS_ST_OPEN_BIT]  = s_ff.drv_open;
          nxt_s.prdata[`MVPS_ST_CLOSE_BIT] = s_ff.drv_close;
          nxt_s.prdata[`MVPS_ST_LOCK_BIT]  =
            (s_ff.st == mvps_pkg::MVPS_LOCK);
          nxt_s.prdata[`MVPS_ST_LOCKD_BIT] = s_ff.locked;
          nxt_s.prdata[`MVPS_ST_DIR_MSB:`MVPS_ST_DIR_LSB] = s_ff.last_dir;
          nxt_s.prdata[`MVPS_ST_CNT_MSB:`MVPS_ST_CNT_LSB] = s_ff.cnt;
        end
        default:           nxt_s.prdata = 32'h0;
      endcase
    end

    // ----------------------------------------------------------------------
    // Motor sequencing, stepped once per operation cycle; a disable in drive or lockout acts on the next clock
    // ----------------------------------------------------------------------
    case (s_ff.st)
      mvps_pkg::MVPS_IDLE: begin
        if (tick && outside) begin
          if (rev && !s_ff.locked && (s_ff.restart != 14'h0)) begin
            nxt_s.st  = mvps_pkg::MVPS_LOCK;
            nxt_s.cnt = {4'h0, s_ff.restart};
          end else if (pulse_ticks != `MVPS_CNT_ZERO) begin
            nxt_s.st       = mvps_pkg::MVPS_DRIVE;
            nxt_s.cnt      = pulse_ticks;
            nxt_s.last_dir = want_dir;
            nxt_s.locked   = 1'b0;
          end
        end
      end
      mvps_pkg::MVPS_DRIVE: begin
        if (!s_ff.enable) begin
          nxt_s.st = mvps_pkg::MVPS_IDLE;
        end else if (tick) begin
          // Reversal mid-pulse drops to idle so the lockout runs first
          if (!outside || (want_dir != s_ff.last_dir)) begin
            nxt_s.st  = mvps_pkg::MVPS_IDLE;
            nxt_s.cnt = `MVPS_CNT_ZERO;
          end else if (s_ff.cnt <= `MVPS_CNT_LAST) begin
            nxt_s.st  = mvps_pkg::MVPS_IDLE;
            nxt_s.cnt = `MVPS_CNT_ZERO;
          end else begin
            nxt_s.cnt = s_ff.cnt - `MVPS_CNT_LAST;
          end
        end
      end
      mvps_pkg::MVPS_LOCK: begin
        if (!s_ff.enable) begin
          nxt_s.st  = mvps_pkg::MVPS_IDLE;
          nxt_s.cnt = `MVPS_CNT_ZERO;
        end else if (tick) begin
          if (s_ff.cnt <= `MVPS_CNT_LAST) begin
            nxt_s.st     = mvps_pkg::MVPS_IDLE;
            nxt_s.cnt    = `MVPS_CNT_ZERO;
            nxt_s.locked = 1'b1;
          end else begin
            nxt_s.cnt = s_ff.cnt - `MVPS_CNT_LAST;
          end
        end
      end
      default: begin
        nxt_s.st = mvps_pkg::MVPS_IDLE;
      end
    endcase
    // Contacts follow the next state, so they can never both be on
    nxt_s.drv_open  = (nxt_s.st == mvps_pkg::MVPS_DRIVE)
                   && (nxt_s.last_dir == mvps_pkg::MVPS_DIR_OPEN);
    nxt_s.drv_close = (nxt_s.st == mvps_pkg::MVPS_DRIVE)
                   && (nxt_s.last_dir == mvps_pkg::MVPS_DIR_CLOSE);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_ff          <= '0;
      s_ff.st       <= mvps_pkg::MVPS_IDLE;
      s_ff.last_dir <= mvps_pkg::MVPS_DIR_NONE;
      s_ff.enable   <= `MVPS_RST_EN;
      s_ff.stroke   <= `MVPS_RST_STROKE;
      s_ff.restart  <= `MVPS_RST_RESTART;
      s_ff.band     <= `MVPS_RST_BAND;
      s_ff.hyst     <= `MVPS_RST_HYST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata          = s_ff.prdata;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && s_ff.slverr;
  assign open_drive_out  = s_ff.drv_open;
  assign close_drive_out = s_ff.drv_close;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_never_both: assert property (
    !(open_drive_out && close_drive_out))
    else $error("open and close contacts on together");
  a_open_dir: assert property (
    $rose(open_drive_out) |-> $past(dev) > 17'sh0)
    else $error("open contact started without positive deviation");
  a_start_band: assert property (
    $rose(open_drive_out || close_drive_out)
      |-> $past(abs_dev) > {2'h0, $past(s_ff.band)} && $past(tick))
    else $error("drive started inside band or off tick");
  a_band_off: assert property (
    tick && s_ff.enable && (abs_dev <= {2'h0, s_ff.band})
      |=> !open_drive_out && !close_drive_out)
    else $error("contact on while deviation inside band");
  a_pulse_len: assert property (
    $rose(open_drive_out || close_drive_out)
      |-> s_ff.cnt == $past(pulse_ticks))
    else $error("pulse length differs from stroke times deviation");
  a_hyst_add: assert property (
    $rose(open_drive_out || close_drive_out) && $past(rev)
      |-> s_ff.cnt == 18'($past(base_ticks) + $past(hyst_ticks)))
    else $error("hysteresis not added on reversal");
  a_lock_quiet: assert property (
    s_ff.st == mvps_pkg::MVPS_LOCK
      |-> !open_drive_out && !close_drive_out)
    else $error("contact on during restart lockout");
  a_lock_len: assert property (
    $rose(s_ff.st == mvps_pkg::MVPS_LOCK)
      |-> s_ff.cnt == {4'h0, $past(s_ff.restart)})
    else $error("lockout loaded with wrong time");
  a_rev_gap: assert property (
    $rose(close_drive_out)
      && $past(s_ff.last_dir) == mvps_pkg::MVPS_DIR_OPEN
      && $past(s_ff.restart) != 14'h0
      |-> $past(s_ff.locked))
    else $error("reversal without restart lockout");
  a_contact_src: assert property (
    open_drive_out |-> s_ff.st == mvps_pkg::MVPS_DRIVE
                    && s_ff.last_dir == mvps_pkg::MVPS_DIR_OPEN)
    else $error("open contact without open drive state");

  c_open_drive: cover property ($rose(open_drive_out));
  c_lockout:    cover property ($rose(s_ff.st == mvps_pkg::MVPS_LOCK));
  c_reversal:   cover property (
    $rose(close_drive_out)
      && s_ff.locked == 1'b0 && $past(s_ff.locked));

endmodule : mvps_top

// file: verif/mvps_valve_model.sv
// Reversible valve motor model: the contacts move the opening feedback.
// Assumes contacts on clk_sys; rate 0 freezes the valve for exact timing.
`timescale 1ns/1ps

module mvps_valve_model (
  input  wire logic        clk_sys,    // System clock
  input  wire logic        rstn,       // Async reset, active low
  input  wire logic        drv_open,   // Open contact
  input  wire logic        drv_close,  // Close contact
  input  wire logic [15:0] rate,       // Travel per clock, 0.01 %
  input  wire logic        preset_en,  // Force a position
  input  wire logic [15:0] preset_val, // Forced position
  output logic      [15:0] opening     // Opening feedback
);
  // ----------------------------------------------------------------
  // Travel, clamped to the stroke ends
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      opening <= 16'h0000;
    end else if (preset_en) begin
      opening <= preset_val;
    end else if (drv_open && !drv_close) begin
      opening <= (opening + rate > 16'h2710) ? 16'h2710 : opening + rate;
    end else if (drv_close && !drv_open) begin
      opening <= (opening < rate) ? 16'h0000 : opening - rate;
    end
  end
endmodule : mvps_valve_model

// file: verif/tb_top.sv
// Self-checking bench for the valve motor stepper.
// Assumes a short operation cycle parameter and a frozen valve in timing.
`timescale 1ns/1ps

module tb_top;
  localparam int OPC = 8;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] mv, fb, rate, pval;
  logic        pen, op, cl, er;
  int          bad_count, total_checks, seed, hi, dly, v;

  mvps_top #(.OP_CYCLE_CLKS(OPC)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .manipulated_value_in(mv),
    .opening_feedback_in(fb), .open_drive_out(op), .close_drive_out(cl));

  mvps_valve_model i_valve (
    .clk_sys(clk_sys), .rstn(rstn), .drv_open(op), .drv_close(cl),
    .rate(rate), .preset_en(pen), .preset_val(pval), .opening(fb));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Held until pready is sampled high, then released
  // No wait limit of its own: a stuck slave is left to the watchdog
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits for a contact to rise, then times how long it stays on
  task automatic measure(logic sel);
    hi  = 0;
    dly = 0;
    while ((sel ? cl : op) !== 1'b1 && dly < 2000) begin
      @(negedge clk_sys);
      dly++;
    end
    while ((sel ? cl : op) === 1'b1 && hi < 2000) begin
      @(negedge clk_sys);
      hi++;
    end
  endtask : measure

  function automatic int exp_ticks(int st, int dv, int hy);
    if (dv < 0) dv = -dv;
    return st * dv / 10000 + st * hy / 10000;
  endfunction : exp_ticks

  function automatic logic [15:0] rpct();
    int r;
    r = $random(seed);
    if (r < 0) r = -r;
    return 16'(r % 10001);
  endfunction : rpct

  // ----------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #600000;
    bad_count++;
    conclude();
  end

  initial begin
    seed = 65;
    bad_count = 0;
    total_checks = 0;
    {psel, penable, pwrite, pen} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {mv, rate, pval} = 48'h0;
    rstn = 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b1, 12'h0ff, 32'hffffffff);
    chk("unmapped write err", 32'h1, 32'(er));
    apb(1'b0, 12'h0ff, 32'h0);
    chk("unmapped read err", 32'h1, 32'(er));
    chk("unmapped read data", 32'h0, rd);
    apb(1'b1, 12'h004, 32'h0000000a);
    apb(1'b1, 12'h008, 32'h00000003);
    apb(1'b1, 12'h00c, 32'h00000064);
    apb(1'b1, 12'h010, 32'h000003e8);
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b0, 12'h010, 32'h0);
    chk("hyst readback", 32'h000003e8, rd);
    // Deviation equal to the band stays off
    mv <= 16'h0064;
    repeat (3 * OPC) begin
      @(negedge clk_sys);
      chk("inside band", 32'h0, 32'({op, cl}));
    end
    @(posedge clk_sys);
    mv <= 16'h07d0;
    measure(1'b0);
    chk("open length", 32'(exp_ticks(10, 2000, 0) * OPC), 32'(hi));
    chk("close idle", 32'h0, 32'(cl));
    @(posedge clk_sys);
    mv <= 16'hf830;
    measure(1'b1);
    chk("close length", 32'(exp_ticks(10, -2000, 1000) * OPC), 32'(hi));
    chk("lockout wait", 32'h1, 32'(dly >= 3 * OPC));
    apb(1'b0, 12'h014, 32'h0);
    chk("last direction", 32'h2, 32'(rd[5:4]));
    rate <= 16'h0014;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      v = rpct();
      pen  <= 1'b1;
      pval <= 16'(v);
      mv   <= (k % 8 == 0) ? 16'(v) : rpct();
      @(posedge clk_sys);
      pen <= 1'b0;
      repeat (3 * OPC) begin
        @(negedge clk_sys);
        chk("never both", 32'h0, 32'(op & cl));
      end
    end
    // Disable in mid-pulse must drop the contacts
    @(posedge clk_sys);
    pen  <= 1'b1;
    pval <= 16'h0000;
    mv   <= 16'h1388;
    @(posedge clk_sys);
    pen  <= 1'b0;
    rate <= 16'h0000;
    dly = 0;
    while (op !== 1'b1 && dly < 200) begin
      @(negedge clk_sys);
      dly++;
    end
    chk("open before disable", 32'h1, 32'(op));
    @(posedge clk_sys);
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge clk_sys);
    repeat (2 * OPC) begin
      @(negedge clk_sys);
      chk("disabled off", 32'h0, 32'({op, cl}));
    end
    conclude();
  end
endmodule : tb_top
